// *** hw/rsm_reset_sequence_manager.v ***
// Reset sequence manager: cause merge, pin drive, delay and vector fetch
//
// Functional notes
// - Three causes: pin, low voltage, watchdog
// - All causes drive pin low through delay
// - Start address fetched from FFFEh-FFFFh
// - Phases: active, delay, vector fetch in order
// - Delay 256 or 4096 cycles by option
// - Vector fetch takes exactly two cycles
// - Pin is input and open-drain output
// - Pin low detected without clock
// - Recognised pulse stretched to output width
// - Pin held low during undervoltage
// - Watchdog underflow drives pin min width
// - Oscillators keep running during reset
// - Clock source option: external, resonator, RC
// - Doubler on: twice; off: half frequency
// - Flags: low voltage sets, clears watchdog
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "rsm_defs.vh"

module rsm_reset_sequence_manager #(
    parameter OUT_MIN_WIDTH = `RSM_OUT_MIN_WIDTH,
    parameter DELAY_LONG    = `RSM_DELAY_LONG,
    parameter DELAY_SHORT   = `RSM_DELAY_SHORT
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // Reset pin, open drain
    input  wire        reset_pin_in,
    output reg         reset_pin_out,
    output reg         reset_pin_oe,
    // Internal causes
    input  wire        undervoltage,
    input  wire        power_on,
    input  wire        watchdog_underflow,
    // CPU side
    output reg         cpu_reset,
    output reg         vector_fetch,
    output reg  [15:0] vector_addr,
    output reg         cpu_start,
    // Clock management
    output reg         osc_enable,
    output reg  [2:0]  clk_src_sel,
    output reg         pll_enable,
    output reg         clk_halve,
    output reg  [1:0]  seq_state,
    // Register port
    input  wire [1:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata
);

    // *****************************************************************
    // Cause capture
    // *****************************************************************

    // Asynchronous catch of a low pin: works with clock stopped
    reg  pin_low_seen;
    reg  pin_ack;
    always @(posedge clk or negedge reset_pin_in) begin
        if (!reset_pin_in) begin
            pin_low_seen <= 1'b1;
        end else if (pin_ack) begin
            pin_low_seen <= 1'b0;
        end
    end

    // Three-stage synchroniser on the caught event and the pin level
    reg  [2:0] ext_sync;
    reg  [2:0] lvl_sync;
    reg        ext_req;
    reg        pin_is_low;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_sync   <= 3'h0;
            lvl_sync   <= 3'h7;
            ext_req    <= 1'b0;
            pin_is_low <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], pin_low_seen};
            lvl_sync <= {lvl_sync[1:0], reset_pin_in};
            if (ext_sync[2] == ext_sync[1]) begin
                ext_req <= ext_sync[2];
            end
            if (lvl_sync[2] == lvl_sync[1]) begin
                pin_is_low <= ~lvl_sync[2];
            end
        end
    end

    // Clear the catch once the synchroniser reports it
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_ack <= 1'b0;
        end else begin
            pin_ack <= ext_req;
        end
    end

    // Supply and watchdog sync
    reg  [2:0] uv_sync;
    reg  [2:0] wd_sync;
    reg        uv_lvl;
    reg        wd_lvl;
    reg        wd_prev;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            uv_sync <= 3'h0;
            wd_sync <= 3'h0;
            uv_lvl  <= 1'b0;
            wd_lvl  <= 1'b0;
            wd_prev <= 1'b0;
        end else begin
            uv_sync <= {uv_sync[1:0], undervoltage | power_on};
            wd_sync <= {wd_sync[1:0], watchdog_underflow};
            if (uv_sync[2] == uv_sync[1]) begin
                uv_lvl <= uv_sync[2];
            end
            if (wd_sync[2] == wd_sync[1]) begin
                wd_lvl <= wd_sync[2];
            end
            wd_prev <= wd_lvl;
        end
    end

    // The catch also sees our own drive of the pin. Mask it while we
    // drive and for eight cycles after, which covers the latency of the
    // catch and its synchroniser. A real pulse in that window is lost.
    reg  [7:0] oe_hist;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oe_hist <= 8'hff;
        end else begin
            oe_hist <= {oe_hist[6:0], reset_pin_oe};
        end
    end

    // External cause only when the low level is not our own
    wire own_drive = reset_pin_oe | (|oe_hist);
    wire ext_cause = ext_req & ~own_drive;

    wire wd_event  = wd_lvl & ~wd_prev;
    // Exactly three causes merge here
    wire any_cause = ext_cause | uv_lvl | wd_event;

    // *****************************************************************
    // Sequencer
    // *****************************************************************

    localparam ST_RUN    = `RSM_ST_RUN;
    localparam ST_ACTIVE = `RSM_ST_ACTIVE;
    localparam ST_DELAY  = `RSM_ST_DELAY;
    localparam ST_FETCH  = `RSM_ST_FETCH;

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [12:0] cnt;
    reg  [12:0] next_cnt;
    reg  [7:0]  option;
    wire [12:0] delay_len = option[`RSM_BIT_LONG_DELAY] ?
                            DELAY_LONG[12:0] : DELAY_SHORT[12:0];

    // Outside party still pulling the pin, not our own drive
    wire pin_is_low_ext = pin_is_low & ~reset_pin_oe;

    // Phase order and restart on any cause
    always @* begin
        next_state = state;
        next_cnt   = cnt + 13'h1;
        case (state)
            ST_RUN: begin
                next_cnt = 13'h0;
                if (any_cause) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                // Count up to the output width, then hold the count
                if (cnt < OUT_MIN_WIDTH[12:0]) begin
                    next_cnt = cnt + 13'h1;
                end else begin
                    next_cnt = cnt;
                end
                // Our drive stops at the width so that an outside hold
                // becomes visible; it or an undervoltage keeps us here
                if (cnt >= OUT_MIN_WIDTH[12:0]
                        && !uv_lvl
                        && !pin_is_low_ext) begin
                    next_state = ST_DELAY;
                    next_cnt   = 13'h0;
                end
            end
            ST_DELAY: begin
                if (any_cause) begin
                    next_state = ST_ACTIVE;
                    next_cnt   = 13'h0;
                end else if (cnt == delay_len - 13'h1) begin
                    next_state = ST_FETCH;
                    next_cnt   = 13'h0;
                end
            end
            default: begin
                if (any_cause) begin
                    next_state = ST_ACTIVE;
                    next_cnt   = 13'h0;
                end else if (cnt == `RSM_FETCH_CYCLES - 1) begin
                    next_state = ST_RUN;
                    next_cnt   = 13'h0;
                end
            end
        endcase
    end

    // State and counter registers
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_ACTIVE;
            cnt   <= 13'h0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // *****************************************************************
    // Outputs
    // *****************************************************************

    // Pin driven low in delay, and in active up to the width or in undervoltage
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reset_pin_oe  <= 1'b1;
            reset_pin_out <= 1'b0;
            cpu_reset     <= 1'b1;
            vector_fetch  <= 1'b0;
            vector_addr   <= `RSM_VECTOR_LO;
            cpu_start     <= 1'b0;
            seq_state     <= ST_ACTIVE;
        end else begin
            reset_pin_out <= 1'b0;
            // Active: stretch to the width, and hold in undervoltage;
            // released after that so an outside hold can be sensed
            reset_pin_oe  <= (next_state == ST_ACTIVE &&
                              (next_cnt < OUT_MIN_WIDTH[12:0] ||
                               uv_lvl)) ||
                             next_state == ST_DELAY;
            cpu_reset     <= next_state != ST_RUN;
            vector_fetch  <= next_state == ST_FETCH;
            // Low byte first, high byte second
            vector_addr   <= (next_state == ST_FETCH && next_cnt[0]) ?
                             `RSM_VECTOR_HI : `RSM_VECTOR_LO;
            cpu_start     <= state == ST_FETCH && next_state == ST_RUN;
            seq_state     <= next_state;
        end
    end

    // Clock management follows the option register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_enable  <= 1'b1;
            clk_src_sel <= `RSM_SRC_EXT;
            pll_enable  <= 1'b0;
            clk_halve   <= 1'b1;
        end else begin
            // Never stopped in reset: no restart time at exit
            osc_enable  <= 1'b1;
            clk_src_sel <= option[`RSM_MSB_CLK_SRC:`RSM_LSB_CLK_SRC];
            // Doubler is not meant for the RC source
            pll_enable  <= option[`RSM_BIT_PLL_EN] &&
                           option[`RSM_MSB_CLK_SRC:`RSM_LSB_CLK_SRC]
                           != `RSM_SRC_RC;
            clk_halve   <= ~(option[`RSM_BIT_PLL_EN] &&
                           option[`RSM_MSB_CLK_SRC:`RSM_LSB_CLK_SRC]
                           != `RSM_SRC_RC);
        end
    end

    // *****************************************************************
    // Registers
    // *****************************************************************

    // Cause flags; the hardware set beats a software clear
    reg lv_flag;
    reg wd_flag;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lv_flag <= 1'b0;
            wd_flag <= 1'b0;
        end else begin
            if (uv_lvl) begin
                lv_flag <= 1'b1;
            end else if (reg_wr && reg_addr == `RSM_ADDR_FLAGS &&
                         !reg_wdata[`RSM_BIT_LV_FLAG]) begin
                lv_flag <= 1'b0;
            end
            if (wd_event) begin
                wd_flag <= 1'b1;
            end else if (uv_lvl) begin
                wd_flag <= 1'b0;
            end else if (reg_wr && reg_addr == `RSM_ADDR_FLAGS &&
                         !reg_wdata[`RSM_BIT_WDG_FLAG]) begin
                wd_flag <= 1'b0;
            end
        end
    end

    // Option register stands in for the non-volatile option byte
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            option <= `RSM_OPTION_RESET;
        end else if (reg_wr && reg_addr == `RSM_ADDR_OPTION) begin
            option <= reg_wdata;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `RSM_ADDR_FLAGS) begin
                reg_rdata <= {3'h0, lv_flag, 3'h0, wd_flag};
            end else if (reg_addr == `RSM_ADDR_STATUS) begin
                reg_rdata <= {3'h0, pin_is_low, uv_lvl, ext_cause, state};
            end else if (reg_addr == `RSM_ADDR_OPTION) begin
                reg_rdata <= option;
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// *** pkg/rsm_defs.vh ***
// Constants for the reset sequence manager
`ifndef RSM_DEFS_VH
`define RSM_DEFS_VH

// Register offsets (plain port, 2-bit address)
`define RSM_ADDR_FLAGS      2'h0
`define RSM_ADDR_STATUS     2'h1
`define RSM_ADDR_OPTION     2'h2

// Flag register field positions
`define RSM_BIT_WDG_FLAG    0
`define RSM_BIT_LV_FLAG     4

// Option register field positions and reset value
`define RSM_BIT_LONG_DELAY  0
`define RSM_BIT_PLL_EN      1
`define RSM_LSB_CLK_SRC     2
`define RSM_MSB_CLK_SRC     4
`define RSM_OPTION_RESET    8'h00

// Clock source codes
`define RSM_SRC_EXT         3'h0
`define RSM_SRC_XTAL0       3'h1
`define RSM_SRC_XTAL3       3'h4
`define RSM_SRC_RC          3'h5

// Sequencer states
`define RSM_ST_RUN          2'h0
`define RSM_ST_ACTIVE       2'h1
`define RSM_ST_DELAY        2'h2
`define RSM_ST_FETCH        2'h3

// Timing, in CPU clock cycles
`define RSM_DELAY_SHORT     256
`define RSM_DELAY_LONG      4096
`define RSM_FETCH_CYCLES    2
`define RSM_OUT_MIN_WIDTH   16

// Reset vector
`define RSM_VECTOR_LO       16'hfffe
`define RSM_VECTOR_HI       16'hffff

`endif

// *** verification/rsm_pin_partner.sv ***
// Board-side reset circuit on the open-drain reset pin
`timescale 1ns/10ps
module rsm_pin_partner #(
    parameter [7:0] MIN_IN_WIDTH = 8'h04
) (
    // Clock
    input  wire       clk,
    // Requests from the bench
    input  wire       hold_low,
    input  wire       pulse,
    input  wire [7:0] len,
    // Pin
    input  wire       dev_oe,
    output wire       pin
);
    reg [7:0] left = 8'h00;

    // A pulse is never shorter than the recognition width
    always @(posedge clk) begin
        if (pulse)
            left <= (len < MIN_IN_WIDTH) ? MIN_IN_WIDTH : len;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end
    // Wired-AND with pull-up; blank part keeps the pin low
    assign pin = !(dev_oe || hold_low || left != 8'h00);
endmodule

// *** verification/rsm_reset_sequence_manager_test.sv ***
// Self-checking testbench for the reset sequence manager
`timescale 1ns/10ps
`include "rsm_defs.vh"
module rsm_reset_sequence_manager_test;
    // **********************
    // Bench
    // **********************
    localparam DL = 64; // Long delay, shortened to keep the run brief
    localparam DS = `RSM_DELAY_SHORT;
    localparam W  = `RSM_OUT_MIN_WIDTH;
    reg        clk = 1'b0;
    reg        rstn = 1'b0;
    reg        uv = 1'b0;
    reg        pwr = 1'b0;
    reg        wdg = 1'b0;
    reg [1:0]  ra = 2'h0;
    reg [7:0]  wd = 8'h00;
    reg        wr_s = 1'b0;
    reg        rd_s = 1'b0;
    reg        hold = 1'b1;
    reg        pulse = 1'b0;
    wire       pin;
    wire       oe;
    wire       osc;
    wire [2:0] src;
    wire       pll;
    wire       halve;
    wire [1:0] st;
    wire [7:0] rdata;
    integer    num_errors = 0;
    integer    n_compared = 0;
    integer    i;

    rsm_reset_sequence_manager #(.DELAY_LONG(DL)) i_rsm_reset_sequence_manager (
        .clk(clk), .rstn(rstn), .reset_pin_in(pin), .reset_pin_out(),
        .reset_pin_oe(oe), .undervoltage(uv), .power_on(pwr),
        .watchdog_underflow(wdg), .cpu_reset(), .vector_fetch(),
        .vector_addr(), .cpu_start(), .osc_enable(osc), .clk_src_sel(src),
        .pll_enable(pll), .clk_halve(halve), .seq_state(st),
        .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_rdata(rdata));
    rsm_pin_partner i_rsm_pin_partner (.clk(clk), .hold_low(hold),
        .pulse(pulse), .len(8'h08), .dev_oe(oe), .pin(pin));

    always #2 clk = ~clk;

    task chk(input [15:0] got, input [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task rng(input integer n, input integer lo, input integer hi);
        n_compared = n_compared + 1;
        if (n < lo || n > hi) begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: count %0d", $time, n);
        end
    endtask
    // Bus tasks start and end at a rising edge
    task wr(input [1:0] a, input [7:0] d);
        ra <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task rdc(input [1:0] a, input [7:0] e);
        ra <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        chk(rdata, e);
    endtask
    // Bounded wait for a phase
    task ws(input [1:0] s, input integer lim);
        integer n;
        n = 0;
        while (st !== s && n < lim) begin
            @(posedge clk);
            n = n + 1;
        end
        chk(st, s);
    endtask
    // Low cycles on the pin until it has stood high for ten cycles;
    // the short release between active phase and delay is bridged
    task low_len(input integer lo, input integer hi);
        integer n;
        integer h;
        integer k;
        n = 0;
        h = 0;
        k = 0;
        while (h < 10 && k < 9000) begin
            @(posedge clk);
            k = k + 1;
            if (pin) begin
                h = h + 1;
            end else begin
                n = n + 1;
                h = 0;
            end
        end
        rng(n, lo, hi);
    endtask
    task wdg_pulse;
        wdg <= 1'b1;
        repeat (3) @(posedge clk);
        wdg <= 1'b0;
    endtask

    task t_boot;
        repeat (40) @(posedge clk);
        chk(st, 2'h1);
        chk(osc, 1'b1);
        hold <= 1'b0;
        low_len(DS, DS + 12);
        ws(2'h0, 9000);
        for (i = 0; i < 4; i = i + 1)
            rdc(i[1:0], 8'h00);
        $display("boot done");
    endtask
    task t_opts;
        for (i = 0; i < 12; i = i + 1) begin
            wr(2'h2, {3'h0, i[3:1], i[0], 1'b0});
            rdc(2'h2, {3'h0, i[3:1], i[0], 1'b0});
            chk(src, i[3:1]);
            chk(pll, i[0] && i[3:1] != 3'h5);
            chk(halve, !(i[0] && i[3:1] != 3'h5));
        end
        wr(2'h1, 8'hff);
        wr(2'h3, 8'hff);
        rdc(2'h1, 8'h00);
        rdc(2'h3, 8'h00);
        wr(2'h2, 8'h00);
        $display("options done");
    endtask
    task t_ext;
        pulse <= 1'b1;
        @(posedge clk);
        pulse <= 1'b0;
        low_len(W + DS, W + DS + 12);
        ws(2'h0, 9000);
        rdc(2'h0, 8'h00);
        $display("pin pulse done");
    endtask
    task t_wdg;
        wr(2'h2, 8'h01);
        wdg_pulse;
        low_len(W + DL, W + DL + 12);
        ws(2'h0, 9000);
        rdc(2'h0, 8'h01);
        wr(2'h0, 8'h10);
        rdc(2'h0, 8'h00);
        $display("watchdog done");
    endtask
    // Second cause mid-delay must rerun the whole delay
    task t_restart;
        integer n;
        n = 0;
        wdg_pulse;
        ws(2'h2, 200);
        repeat (20) @(posedge clk);
        wdg_pulse;
        ws(2'h1, 12);
        ws(2'h2, 200);
        while (st === 2'h2 && n < 9000) begin
            @(posedge clk);
            n = n + 1;
        end
        rng(n, DL, DL);
        ws(2'h0, 100);
        rdc(2'h0, 8'h01);
        $display("restart done");
    endtask
    task t_lv;
        for (i = 0; i < 2; i = i + 1) begin
            uv <= (i == 0);
            pwr <= (i == 1);
            repeat (40) @(posedge clk);
            chk(st, 2'h1);
            chk(pin, 1'b0);
            uv <= 1'b0;
            pwr <= 1'b0;
            ws(2'h0, 9000);
            rdc(2'h0, 8'h10);
            wr(2'h0, 8'h00);
        end
        $display("low voltage done");
    endtask

    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_boot;
        t_opts;
        t_ext;
        t_wdg;
        t_restart;
        t_lv;
        end_sim;
    end
    // The run needs some 1200 cycles; 20000 means a hang
    initial begin
        #80000;
        num_errors = num_errors + 1;
        end_sim;
    end
endmodule

// *** verification/rsm_seq_checker_assertions.sv ***
// Port-level assertion checker for the reset sequence manager
`timescale 1ns/10ps
module rsm_seq_checker #(
    parameter OUT_MIN_WIDTH = 16,
    parameter DELAY_LONG    = 4096,
    parameter DELAY_SHORT   = 256
) (
    // Clock and reset
    input wire        clk,
    input wire        rstn,
    // Pin and causes
    input wire        reset_pin_out,
    input wire        reset_pin_oe,
    input wire        undervoltage,
    input wire        watchdog_underflow,
    // CPU and clock side
    input wire        cpu_reset,
    input wire        cpu_start,
    input wire        vector_fetch,
    input wire [15:0] vector_addr,
    input wire [1:0]  seq_state,
    input wire [2:0]  clk_src_sel,
    input wire        pll_enable,
    input wire        clk_halve,
    // Register port
    input wire [1:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr
);
    // ******************************
    // Phase tracking and assertions
    // ******************************
    reg        opt_long;
    reg [15:0] act_cnt;
    reg [15:0] dly_cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Mirror the delay option; counters clear outside their phase
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            opt_long <= 1'b0;
            act_cnt  <= 16'h0000;
            dly_cnt  <= 16'h0000;
        end else begin
            if (reg_wr && reg_addr == 2'h2)
                opt_long <= reg_wdata[0];
            act_cnt <= (seq_state == 2'h1) ? act_cnt + 16'h0001 : 16'h0000;
            dly_cnt <= (seq_state == 2'h2) ? dly_cnt + 16'h0001 : 16'h0000;
        end
    end

    a_phase_order:
    assert property (seq_state != $past(seq_state) |->
        seq_state == $past(seq_state) + 2'h1 || seq_state == 2'h1)
        else $error("phase order broken");
    a_active_width:
    assert property ($past(seq_state) == 2'h1 && seq_state == 2'h2 |->
        act_cnt >= OUT_MIN_WIDTH)
        else $error("active phase too short");
    a_delay_length:
    assert property ($past(seq_state) == 2'h2 && seq_state == 2'h3 |->
        dly_cnt == (opt_long ? DELAY_LONG : DELAY_SHORT))
        else $error("delay length wrong");
    a_fetch_pair:
    assert property ($rose(vector_fetch) |-> vector_addr == 16'hfffe
        ##1 vector_fetch && vector_addr == 16'hffff ##1 !vector_fetch)
        else $error("vector fetch wrong");
    a_start_pulse:
    assert property ($fell(vector_fetch) |-> ##[0:1] cpu_start ##1 !cpu_start)
        else $error("start pulse missing");
    a_pin_in_delay:
    assert property (seq_state == 2'h2 |-> reset_pin_oe && cpu_reset)
        else $error("pin released in delay");
    a_pin_drain:
    assert property (reset_pin_oe |-> !reset_pin_out)
        else $error("pin driven high");
    a_uv_hold:
    assert property (undervoltage [*8] |-> seq_state == 2'h1 && reset_pin_oe)
        else $error("undervoltage not held");
    a_wdg_cause:
    assert property ($rose(watchdog_underflow) |-> ##[1:6] seq_state == 2'h1)
        else $error("watchdog ignored");
    a_clk_option:
    assert property (clk_halve != pll_enable
        && !(pll_enable && clk_src_sel == 3'h5))
        else $error("clock option wrong");
endmodule

bind rsm_reset_sequence_manager rsm_seq_checker #(
    .OUT_MIN_WIDTH(OUT_MIN_WIDTH), .DELAY_LONG(DELAY_LONG),
    .DELAY_SHORT(DELAY_SHORT)
) i_rsm_seq_checker (
    .clk(clk), .rstn(rstn), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .undervoltage(undervoltage),
    .watchdog_underflow(watchdog_underflow), .cpu_reset(cpu_reset),
    .cpu_start(cpu_start), .vector_fetch(vector_fetch),
    .vector_addr(vector_addr), .seq_state(seq_state),
    .clk_src_sel(clk_src_sel), .pll_enable(pll_enable),
    .clk_halve(clk_halve), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr)
);
